/* dmac_regs.svh */
// Register offsets, field positions and reset values of the DMA bus interface.
`ifndef DMAC_REGS_SVH
`define DMAC_REGS_SVH

// ----------------------------------------------------------------------------
// Host register offsets on the low address nibble
// ----------------------------------------------------------------------------
`define DMAC_ADDR_GLOBAL  3
`define DMAC_ADDR_COUNT   0
`define DMAC_OFF_CMD      4'h8
`define DMAC_OFF_REQ      4'h9
`define DMAC_OFF_MASK1    4'ha
`define DMAC_OFF_MODE     4'hb
`define DMAC_OFF_CLRBP    4'hc
`define DMAC_OFF_CLEAR    4'hd
`define DMAC_OFF_MASKALL  4'hf

// ----------------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------------
`define DMAC_CMD_DISABLE  2
`define DMAC_CMD_REQ_LOW  6
`define DMAC_CMD_GNT_HIGH 7
`define DMAC_BIT_SET      2
`define DMAC_MODE_AUTO    2
`define DMAC_MODE_DEC     3
`define DMAC_MODE_XF_HI   5
`define DMAC_MODE_XF_LO   4
`define DMAC_TYPE_WRITE   2'b01
`define DMAC_TYPE_READ    2'b10
`define DMAC_XF_DEMAND    2'b00
`define DMAC_XF_SINGLE    2'b01
`define DMAC_XF_BLOCK     2'b10

// ----------------------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------------------
`define DMAC_CMD_RESET    8'h00
`define DMAC_MASK_RESET   4'hf
`define DMAC_NIB_ZERO     4'h0
`define DMAC_BYTE_ZERO    8'h00
`define DMAC_WORD_ZERO    16'h0000
`define DMAC_MODE_RESET   6'h00
`define DMAC_STEP         16'h0001

`endif

/* dmac_pkg.sv */
// Types shared by the DMA bus interface.
package dmac_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HOLD = 3'b001,
    ST_S1   = 3'b010,
    ST_S2   = 3'b011,
    ST_S3   = 3'b100,
    ST_S4   = 3'b101
  } dmac_state_t;
  typedef logic [1:0] dmac_chan_t;
endpackage : dmac_pkg

/* dmac_bus_interface.sv */
// Pin-level bus interface and register complement of a four-channel DMA controller.
`include "dmac_regs.svh"

// Notes on behaviour
// - I/O write strobe is host input when idle, device output during service.
// - End-of-service is open-drain active low; outside party may pull it low.
// - Terminal count on any channel pulses end-of-service low.
// - End of service ends transfer, clears request, reloads currents if autoinit.
// - End of service sets mask and count-exhausted bits unless autoinit.
// - Low address nibble selects registers when idle, carries address when active.
// - Middle address nibble driven only during service, floating otherwise.
// - Hold request asserted while any unmasked valid channel request exists.
// - Per-channel grant with programmable level, active low after reset.
// - Active-high address enable gates the external upper address latch.
// - Active-high upper address strobe pulses to capture upper byte.
// - Active-low memory read strobe during memory-to-peripheral transfers.
// - Active-low memory write strobe during peripheral-to-memory transfers.
// - Each channel holds base and current address and word count.
// - Temporary address, count and data registers plus status and command.
// - Reset clears command, status, request, temporaries, byte pointer; sets masks.
// - Upper eight address bits go out on data lines during service.
module dmac_bus_interface (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       chipSelectN,
  input  wire logic       ioWriteStrobeIn,
  output logic            ioWriteStrobeOut,
  output logic            ioWriteStrobeOe,
  input  wire logic       ioReadStrobeIn,
  output logic            ioReadStrobeOut,
  output logic            ioReadStrobeOe,
  input  wire logic       endOfServiceNIn,
  output logic            endOfServiceNOut,
  output logic            endOfServiceNOe,
  input  wire logic [3:0] lowAddressNibbleIn,
  output logic      [3:0] lowAddressNibbleOut,
  output logic            lowAddressNibbleOe,
  output logic      [3:0] midAddressNibble,
  output logic            midAddressNibbleOe,
  output logic            busHoldRequest,
  input  wire logic       busHoldGrant,
  input  wire logic [3:0] channelRequest,
  output logic      [3:0] channelGrant,
  output logic            addressDriveEnable,
  output logic            upperAddressStrobe,
  output logic            memoryReadStrobeN,
  output logic            memoryWriteStrobeN,
  output logic            memoryStrobeOe,
  input  wire logic [7:0] systemDataIn,
  output logic      [7:0] systemDataOut,
  output logic            systemDataOe
);

  // --------------------------------------------------------------------------
  // Register complement
  // --------------------------------------------------------------------------
  logic [15:0]          baseAddr   [4];
  logic [15:0]          baseCount  [4];
  logic [15:0]          curAddr    [4];
  logic [15:0]          curCount   [4];
  logic [5:0]           mode       [4];
  logic [15:0]          tempAddr;
  logic [15:0]          tempCount;
  logic [7:0]           tempData;
  logic [7:0]           command;
  logic [7:0]           status;
  logic [3:0]           mask;
  logic [3:0]           softReq;
  logic                 bytePtr;
  logic                 ioWrPrev;
  logic                 ioRdPrev;
  logic                 eopSeen;
  dmac_pkg::dmac_state_t state;
  dmac_pkg::dmac_state_t next_state;
  dmac_pkg::dmac_chan_t  actCh;

  // Address step used for both address and count updates.
  function automatic logic [15:0] dmac_step(input logic [15:0] a, input logic dec);
    return dec ? (a - `DMAC_STEP) : (a + `DMAC_STEP);
  endfunction : dmac_step

  // Fixed priority pick, channel zero first.
  function automatic dmac_pkg::dmac_chan_t dmac_first(input logic [3:0] v);
    dmac_pkg::dmac_chan_t c;
    c = 2'h3;
    for (int i = 3; i >= 0; i--) begin
      if (v[i]) begin
        c = 2'(i);
      end
    end
    return c;
  endfunction : dmac_first

  // --------------------------------------------------------------------------
  // Request qualification and host access decode
  // --------------------------------------------------------------------------
  // Requests are aligned to their programmed level, then masked.
  wire [3:0] hwReq    = command[`DMAC_CMD_REQ_LOW] ? ~channelRequest : channelRequest;
  wire [3:0] validReq = (hwReq | softReq) & ~mask & {4{~command[`DMAC_CMD_DISABLE]}};
  wire       anyValid = |validReq;
  wire       progCond = (state == dmac_pkg::ST_IDLE) && !chipSelectN && !busHoldGrant;
  wire       hostWrite = progCond && !ioWrPrev && ioWriteStrobeIn;
  wire       hostReadEnd = progCond && !ioRdPrev && ioReadStrobeIn;
  wire       hostReading = progCond && !ioReadStrobeIn;
  wire [3:0] regSel   = lowAddressNibbleIn;
  wire       chanReg  = !regSel[`DMAC_ADDR_GLOBAL];
  wire [1:0] selCh    = regSel[2:1];
  wire       selCount = regSel[`DMAC_ADDR_COUNT];
  wire [1:0] dataCh   = systemDataIn[1:0];
  wire       masterClear = hostWrite && (regSel == `DMAC_OFF_CLEAR);

  // Read selection for the host.
  wire [15:0] chWord  = selCount ? curCount[selCh] : curAddr[selCh];
  wire [7:0]  chByte  = bytePtr ? chWord[15:8] : chWord[7:0];
  wire [7:0]  readMux = chanReg ? chByte :
                        (regSel == `DMAC_OFF_CMD)   ? status :
                        (regSel == `DMAC_OFF_CLEAR) ? tempData : `DMAC_BYTE_ZERO;

  // --------------------------------------------------------------------------
  // Service sequencing terms
  // --------------------------------------------------------------------------
  wire [5:0]  actMode  = mode[actCh];
  wire [1:0]  actXf    = actMode[`DMAC_MODE_XF_HI:`DMAC_MODE_XF_LO];
  wire [1:0]  actType  = actMode[1:0];
  wire        autoInit = actMode[`DMAC_MODE_AUTO];
  wire        tcHit    = (curCount[actCh] == `DMAC_WORD_ZERO);
  wire        endNow   = tcHit || eopSeen || !endOfServiceNIn;
  wire [15:0] stepAddr = dmac_step(curAddr[actCh], actMode[`DMAC_MODE_DEC]);
  wire [15:0] nextAddr = (state == dmac_pkg::ST_S4) ? stepAddr : curAddr[actCh];
  wire        inSvcNext = (next_state == dmac_pkg::ST_S1) || (next_state == dmac_pkg::ST_S2) ||
                          (next_state == dmac_pkg::ST_S3) || (next_state == dmac_pkg::ST_S4);
  wire        strobeNext = (next_state == dmac_pkg::ST_S2) || (next_state == dmac_pkg::ST_S3);
  wire [3:0]  grantAct = inSvcNext ? (4'h1 << actCh) : `DMAC_NIB_ZERO;

  // Next state: idle, hold wait, then four working states per byte.
  always_comb begin
    next_state = state;
    case (state)
      dmac_pkg::ST_IDLE: begin
        if (anyValid) begin
          next_state = dmac_pkg::ST_HOLD;
        end
      end
      dmac_pkg::ST_HOLD: begin
        if (busHoldGrant) begin
          next_state = dmac_pkg::ST_S1;
        end else if (!anyValid) begin
          next_state = dmac_pkg::ST_IDLE;
        end
      end
      dmac_pkg::ST_S1: next_state = dmac_pkg::ST_S2;
      dmac_pkg::ST_S2: next_state = dmac_pkg::ST_S3;
      dmac_pkg::ST_S3: next_state = dmac_pkg::ST_S4;
      dmac_pkg::ST_S4: begin
        if (endNow || (actXf == `DMAC_XF_SINGLE)) begin
          next_state = dmac_pkg::ST_IDLE;
        end else if (actXf == `DMAC_XF_BLOCK) begin
          next_state = dmac_pkg::ST_S1;
        end else if ((actXf == `DMAC_XF_DEMAND) && validReq[actCh]) begin
          next_state = dmac_pkg::ST_S1;
        end else begin
          next_state = dmac_pkg::ST_IDLE;
        end
      end
      default: next_state = dmac_pkg::ST_IDLE;
    endcase
  end

  // State, channel choice and strobe history.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || masterClear) begin
      state    <= dmac_pkg::ST_IDLE;
      actCh    <= 2'h0;
      ioWrPrev <= 1'b1;
      ioRdPrev <= 1'b1;
      eopSeen  <= 1'b0;
    end else begin
      state    <= next_state;
      ioWrPrev <= ioWriteStrobeIn;
      ioRdPrev <= ioReadStrobeIn;
      if (state == dmac_pkg::ST_IDLE) begin
        actCh <= dmac_first(validReq);
      end
      eopSeen <= (state != dmac_pkg::ST_IDLE) && (state != dmac_pkg::ST_S4) &&
                 (eopSeen || !endOfServiceNIn);
    end
  end

  // --------------------------------------------------------------------------
  // Register file: host programming and end-of-byte updates
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || masterClear) begin
      command <= `DMAC_CMD_RESET;
      status  <= `DMAC_BYTE_ZERO;
      softReq <= `DMAC_NIB_ZERO;
      mask    <= `DMAC_MASK_RESET;
      bytePtr <= 1'b0;
      tempAddr  <= `DMAC_WORD_ZERO;
      tempCount <= `DMAC_WORD_ZERO;
      tempData  <= `DMAC_BYTE_ZERO;
      for (int i = 0; i < 4; i++) begin
        baseAddr[i]  <= `DMAC_WORD_ZERO;
        baseCount[i] <= `DMAC_WORD_ZERO;
        curAddr[i]   <= `DMAC_WORD_ZERO;
        curCount[i]  <= `DMAC_WORD_ZERO;
        mode[i]      <= `DMAC_MODE_RESET;
      end
    end else begin
      status[7:4] <= hwReq;
      if (hostReadEnd && (regSel == `DMAC_OFF_CMD)) begin
        status[3:0] <= `DMAC_NIB_ZERO;
      end
      if ((hostWrite || hostReadEnd) && chanReg) begin
        bytePtr <= ~bytePtr;
      end
      if (hostWrite) begin
        if (chanReg && selCount && bytePtr) begin
          baseCount[selCh][15:8] <= systemDataIn;
          curCount[selCh][15:8]  <= systemDataIn;
        end else if (chanReg && selCount) begin
          baseCount[selCh][7:0] <= systemDataIn;
          curCount[selCh][7:0]  <= systemDataIn;
        end else if (chanReg && bytePtr) begin
          baseAddr[selCh][15:8] <= systemDataIn;
          curAddr[selCh][15:8]  <= systemDataIn;
        end else if (chanReg) begin
          baseAddr[selCh][7:0] <= systemDataIn;
          curAddr[selCh][7:0]  <= systemDataIn;
        end
        case (regSel)
          `DMAC_OFF_CMD:     command <= systemDataIn;
          `DMAC_OFF_REQ:     softReq[dataCh] <= systemDataIn[`DMAC_BIT_SET];
          `DMAC_OFF_MASK1:   mask[dataCh] <= systemDataIn[`DMAC_BIT_SET];
          `DMAC_OFF_MODE:    mode[dataCh] <= systemDataIn[7:2];
          `DMAC_OFF_CLRBP:   bytePtr <= 1'b0;
          `DMAC_OFF_MASKALL: mask <= systemDataIn[3:0];
          default: ;
        endcase
      end
      if (state == dmac_pkg::ST_S3) begin
        tempData <= systemDataIn;
      end
      // End of a byte: step address and count, then close the service if due.
      if (state == dmac_pkg::ST_S4) begin
        tempAddr  <= curAddr[actCh];
        tempCount <= curCount[actCh];
        curAddr[actCh]  <= stepAddr;
        curCount[actCh] <= dmac_step(curCount[actCh], 1'b1);
        if (endNow) begin
          softReq[actCh] <= 1'b0;
          if (autoInit) begin
            curAddr[actCh]  <= baseAddr[actCh];
            curCount[actCh] <= baseCount[actCh];
          end else begin
            mask[actCh]   <= 1'b1;
            status[actCh] <= 1'b1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registered pin drivers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busHoldRequest      <= 1'b0;
      addressDriveEnable  <= 1'b0;
      upperAddressStrobe  <= 1'b0;
      lowAddressNibbleOut <= `DMAC_NIB_ZERO;
      lowAddressNibbleOe  <= 1'b0;
      midAddressNibble    <= `DMAC_NIB_ZERO;
      midAddressNibbleOe  <= 1'b0;
      systemDataOut       <= `DMAC_BYTE_ZERO;
      systemDataOe        <= 1'b0;
      ioWriteStrobeOut    <= 1'b1;
      ioReadStrobeOut     <= 1'b1;
      ioWriteStrobeOe     <= 1'b0;
      ioReadStrobeOe      <= 1'b0;
      memoryReadStrobeN   <= 1'b1;
      memoryWriteStrobeN  <= 1'b1;
      memoryStrobeOe      <= 1'b0;
      channelGrant        <= `DMAC_MASK_RESET;
      endOfServiceNOut    <= 1'b0;
      endOfServiceNOe     <= 1'b0;
    end else begin
      busHoldRequest      <= (next_state != dmac_pkg::ST_IDLE);
      addressDriveEnable  <= inSvcNext;
      upperAddressStrobe  <= (next_state == dmac_pkg::ST_S1);
      lowAddressNibbleOut <= nextAddr[3:0];
      lowAddressNibbleOe  <= inSvcNext;
      midAddressNibble    <= nextAddr[7:4];
      midAddressNibbleOe  <= inSvcNext;
      systemDataOut       <= (next_state == dmac_pkg::ST_S1) ? nextAddr[15:8] : readMux;
      systemDataOe        <= (next_state == dmac_pkg::ST_S1) || hostReading;
      ioWriteStrobeOut    <= ~(strobeNext && (actType == `DMAC_TYPE_READ));
      ioReadStrobeOut     <= ~(strobeNext && (actType == `DMAC_TYPE_WRITE));
      ioWriteStrobeOe     <= inSvcNext;
      ioReadStrobeOe      <= inSvcNext;
      memoryReadStrobeN   <= ~(strobeNext && (actType == `DMAC_TYPE_READ));
      memoryWriteStrobeN  <= ~(strobeNext && (actType == `DMAC_TYPE_WRITE));
      memoryStrobeOe      <= inSvcNext;
      channelGrant        <= command[`DMAC_CMD_GNT_HIGH] ? grantAct : ~grantAct;
      endOfServiceNOut    <= 1'b0;
      endOfServiceNOe     <= (state == dmac_pkg::ST_S4) && tcHit;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_hold_on_request: assert property ((state == dmac_pkg::ST_IDLE) && anyValid |=> busHoldRequest)
    else $error("hold request missing for pending channel");
  a_grant_wait: assert property ((state == dmac_pkg::ST_HOLD) && !busHoldGrant && anyValid |=> (state == dmac_pkg::ST_HOLD))
    else $error("service began without grant");
  a_tc_pulse: assert property ((state == dmac_pkg::ST_S4) && tcHit |=> endOfServiceNOe ##1 !endOfServiceNOe)
    else $error("end-of-service pulse wrong on terminal count");
  a_mask_on_end: assert property ((state == dmac_pkg::ST_S4) && endNow && !autoInit |=> mask[$past(actCh)] && status[$past(actCh)])
    else $error("mask or count bit not set at end of service");
  a_autoinit_reload: assert property ((state == dmac_pkg::ST_S4) && endNow && autoInit |=> curCount[$past(actCh)] == baseCount[$past(actCh)])
    else $error("autoinitialize reload missing");
  a_mid_float: assert property ((state == dmac_pkg::ST_IDLE) || (state == dmac_pkg::ST_HOLD) |-> !midAddressNibbleOe && !addressDriveEnable)
    else $error("address driven outside service");
  a_strobe_single: assert property ($rose(upperAddressStrobe) |=> !upperAddressStrobe ##1 !upperAddressStrobe)
    else $error("address strobe longer than one cycle");
  a_iow_input: assert property ((state == dmac_pkg::ST_IDLE) |-> !ioWriteStrobeOe && !lowAddressNibbleOe)
    else $error("pins driven while idle");
  a_upper_byte: assert property ((state == dmac_pkg::ST_S1) |-> systemDataOe && (systemDataOut == curAddr[actCh][15:8]))
    else $error("upper address byte not on data lines");
  a_reset_mask: assert property (@(posedge clk_sys) disable iff (1'b0) !rst_n |=> (mask == `DMAC_MASK_RESET) && (command == `DMAC_CMD_RESET))
    else $error("reset did not set masks");

endmodule : dmac_bus_interface

/* dmac_partner_model.sv */
// Host hold handshake, requesting peripherals and the end-of-service wire for the DMA bench.
module dmac_partner_model (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       busHoldRequest,
  output logic            busHoldGrant,
  input  wire logic [3:0] channelGrant,
  output logic      [3:0] channelRequest,
  input  wire logic [3:0] raise,
  input  wire logic       endOfServiceNOut,
  input  wire logic       endOfServiceNOe,
  input  wire logic       pullEnd,
  output logic            endOfServiceNIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       holdSeen = 1'b0;
  logic       grantReg = 1'b0;
  logic [3:0] reqReg   = 4'h0;

  // The wire idles high through its pull-up; either party may pull it low.
  assign endOfServiceNIn = ~((endOfServiceNOe & ~endOfServiceNOut) | pullEnd);
  assign busHoldGrant    = grantReg;
  assign channelRequest  = reqReg;

  // The host grants no sooner than two full clocks after the hold request, and drops one clock after it.
  always @(posedge clk_sys) begin
    holdSeen <= rst_n & busHoldRequest;
    grantReg <= rst_n & busHoldRequest & holdSeen;
  end

  // Each peripheral keeps its active-high request up until its active-low grant arrives.
  always @(posedge clk_sys) begin
    reqReg <= rst_n ? ((reqReg | raise) & channelGrant) : 4'h0;
  end
endmodule : dmac_partner_model

/* dmac_bus_interface_test.sv */
// Self-checking bench for the DMA bus interface with a host and peripheral model.
`include "dmac_regs.svh"
module dmac_bus_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 0, rst_n = 0, chipSelectN = 1, hostIow = 1, hostIor = 1, pullEnd = 0, lastOe = 0;
  logic [3:0]  hostAddr = 4'h0, raise = 4'h0, lowAddressNibbleIn, lowAddressNibbleOut, midAddressNibble;
  logic [3:0]  channelGrant, channelRequest;
  logic [7:0]  hostData = 8'h00, systemDataIn, systemDataOut;
  logic [15:0] addr;
  logic [39:0] cnt = 40'h0;
  logic [39:0] expQ[$];
  int          seed = 51667, badCount = 0, nChecks = 0, cycles = 0, i;
  logic        ioWriteStrobeIn, ioWriteStrobeOut, ioWriteStrobeOe, ioReadStrobeIn, ioReadStrobeOut, ioReadStrobeOe;
  logic        endOfServiceNIn, endOfServiceNOut, endOfServiceNOe, lowAddressNibbleOe, midAddressNibbleOe;
  logic        busHoldRequest, busHoldGrant, addressDriveEnable, upperAddressStrobe, systemDataOe;
  logic        memoryReadStrobeN, memoryWriteStrobeN, memoryStrobeOe;

  // Shared lines carry the device's value while it drives them, the host's otherwise.
  assign ioWriteStrobeIn    = (ioWriteStrobeOe === 1'b1) ? ioWriteStrobeOut : hostIow;
  assign ioReadStrobeIn     = (ioReadStrobeOe === 1'b1) ? ioReadStrobeOut : hostIor;
  assign lowAddressNibbleIn = (lowAddressNibbleOe === 1'b1) ? lowAddressNibbleOut : hostAddr;
  assign systemDataIn       = (systemDataOe === 1'b1) ? systemDataOut : hostData;

  dmac_bus_interface u_dmac_bus_interface (.clk_sys(clk_sys), .rst_n(rst_n), .chipSelectN(chipSelectN),
    .ioWriteStrobeIn(ioWriteStrobeIn), .ioWriteStrobeOut(ioWriteStrobeOut), .ioWriteStrobeOe(ioWriteStrobeOe),
    .ioReadStrobeIn(ioReadStrobeIn), .ioReadStrobeOut(ioReadStrobeOut), .ioReadStrobeOe(ioReadStrobeOe),
    .endOfServiceNIn(endOfServiceNIn), .endOfServiceNOut(endOfServiceNOut), .endOfServiceNOe(endOfServiceNOe),
    .lowAddressNibbleIn(lowAddressNibbleIn), .lowAddressNibbleOut(lowAddressNibbleOut),
    .lowAddressNibbleOe(lowAddressNibbleOe), .midAddressNibble(midAddressNibble),
    .midAddressNibbleOe(midAddressNibbleOe), .busHoldRequest(busHoldRequest), .busHoldGrant(busHoldGrant),
    .channelRequest(channelRequest), .channelGrant(channelGrant), .addressDriveEnable(addressDriveEnable),
    .upperAddressStrobe(upperAddressStrobe), .memoryReadStrobeN(memoryReadStrobeN),
    .memoryWriteStrobeN(memoryWriteStrobeN), .memoryStrobeOe(memoryStrobeOe), .systemDataIn(systemDataIn),
    .systemDataOut(systemDataOut), .systemDataOe(systemDataOe));

  dmac_partner_model u_dmac_partner_model (.clk_sys(clk_sys), .rst_n(rst_n), .busHoldRequest(busHoldRequest),
    .busHoldGrant(busHoldGrant), .channelGrant(channelGrant), .channelRequest(channelRequest), .raise(raise),
    .endOfServiceNOut(endOfServiceNOut), .endOfServiceNOe(endOfServiceNOe), .pullEnd(pullEnd),
    .endOfServiceNIn(endOfServiceNIn));

  // Clock and a cycle ceiling that cuts a hang short.
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      giveVerdict();
    end
  end

  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : giveVerdict

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Takes the oldest note; an unexpected result meets an impossible value.
  task automatic take(input logic [39:0] got);
    check(got, (expQ.size() == 0) ? 40'hff_ffff_ffff : expQ.pop_front());
  endtask : take

  // Watch settled outputs at the falling edge: addresses, read data, strobe and pulse counts.
  always @(negedge clk_sys) begin
    if (rst_n) begin
      if (upperAddressStrobe) begin
        take({16'h0, channelGrant, addressDriveEnable, midAddressNibbleOe, lowAddressNibbleOe, 1'b0,
              systemDataOut, midAddressNibble, lowAddressNibbleOut});
      end else if (systemDataOe && !lastOe && !busHoldGrant) begin
        take({32'h0, systemDataOut});
      end
      if (!busHoldRequest && !busHoldGrant) begin
        check({38'h0, midAddressNibbleOe, addressDriveEnable}, 40'h0);
      end
      if (memoryStrobeOe && !memoryWriteStrobeN) cnt[39:32] = cnt[39:32] + 8'h01;
      if (memoryStrobeOe && !memoryReadStrobeN) cnt[31:24] = cnt[31:24] + 8'h01;
      if (ioWriteStrobeOe && !ioWriteStrobeOut) cnt[23:16] = cnt[23:16] + 8'h01;
      if (ioReadStrobeOe && !ioReadStrobeOut) cnt[15:8] = cnt[15:8] + 8'h01;
      if (endOfServiceNOe && !endOfServiceNOut) cnt[7:0] = cnt[7:0] + 8'h01;
    end
    lastOe = systemDataOe;
  end

  // Host register cycles; every task starts and ends just after a rising edge.
  task automatic wr(input logic [3:0] off, input logic [7:0] d);
    chipSelectN = 1'b0;
    hostAddr = off;
    hostData = d;
    hostIow = 1'b0;
    @(posedge clk_sys);
    #2 hostIow = 1'b1;
    @(posedge clk_sys);
    #2 chipSelectN = 1'b1;
    // One idle edge keeps the select high before the next access starts.
    @(posedge clk_sys);
    #2;
  endtask : wr

  task automatic rd(input logic [3:0] off, input logic [7:0] e);
    expQ.push_back({32'h0, e});
    chipSelectN = 1'b0;
    hostAddr = off;
    hostIor = 1'b0;
    repeat (2) @(posedge clk_sys);
    #2 hostIor = 1'b1;
    // The select stays low until the rising strobe is taken, so the read end counts.
    @(posedge clk_sys);
    #2 chipSelectN = 1'b1;
    @(posedge clk_sys);
    #2;
  endtask : rd

  task automatic setup(input logic [1:0] ch, input logic [15:0] a, input logic [15:0] c, input logic [5:0] m);
    wr(`DMAC_OFF_CLRBP, 8'h00);
    wr({1'b0, ch, 1'b0}, a[7:0]);
    wr({1'b0, ch, 1'b0}, a[15:8]);
    wr({1'b0, ch, 1'b1}, c[7:0]);
    wr({1'b0, ch, 1'b1}, c[15:8]);
    wr(`DMAC_OFF_MODE, {m, ch});
  endtask : setup

  // Raises requests and runs until the hold handshake is over, optionally cutting at the first byte.
  task automatic serve(input logic [3:0] bits, input logic cut);
    int n;
    raise = bits;
    @(posedge clk_sys);
    #2 raise = 4'h0;
    for (n = 0; n < 300 && (n < 3 || busHoldRequest || busHoldGrant); n++) begin
      if (cut && upperAddressStrobe) pullEnd = 1'b1;
      @(posedge clk_sys);
      #2;
    end
    pullEnd = 1'b0;
  endtask : serve

  task automatic poke(input logic [3:0] bits);
    raise = bits;
    @(posedge clk_sys);
    #2 raise = 4'h0;
    repeat (4) @(posedge clk_sys);
    #2;
    check({39'h0, busHoldRequest}, 40'h0);
  endtask : poke

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    @(posedge clk_sys);
    #2;
    rd(`DMAC_OFF_CMD, 8'h00);
    check({36'h0, channelGrant}, 40'hf);
    $display("test reset done");
    // Single transfers, peripheral to memory, on channel 1; masked until the last moment.
    addr = 16'($random(seed));
    setup(2'd1, addr, 16'h0002, 6'b01_0_0_01);
    poke(4'h2);
    for (i = 0; i < 3; i++) expQ.push_back({16'h0, 4'hd, 4'he, addr + 16'(i)});
    cnt = 40'h0;
    wr(`DMAC_OFF_MASK1, 8'h01);
    for (i = 0; i < 3; i++) serve((i == 0) ? 4'h0 : 4'h2, 1'b0);
    check(cnt, {8'd6, 8'd0, 8'd0, 8'd6, 8'd1});
    rd(`DMAC_OFF_CMD, 8'h02);
    $display("test single done");
    // Block transfers with autoinit, memory to peripheral, counting down on channel 2.
    addr = 16'($random(seed));
    setup(2'd2, addr, 16'h0001, 6'b10_1_1_10);
    wr(`DMAC_OFF_MASK1, 8'h02);
    cnt = 40'h0;
    for (i = 0; i < 2; i++) expQ.push_back({16'h0, 4'hb, 4'he, addr - 16'(i)});
    serve(4'h4, 1'b0);
    wr(`DMAC_OFF_CLRBP, 8'h00);
    rd(4'h4, addr[7:0]);
    rd(4'h4, addr[15:8]);
    for (i = 0; i < 2; i++) expQ.push_back({16'h0, 4'hb, 4'he, addr - 16'(i)});
    serve(4'h4, 1'b0);
    check(cnt, {8'd0, 8'd8, 8'd8, 8'd0, 8'd2});
    $display("test autoinit done");
    // Block transfer on channel 3 cut short by the outside party pulling end-of-service low.
    addr = 16'($random(seed));
    setup(2'd3, addr, 16'h0005, 6'b10_0_0_01);
    wr(`DMAC_OFF_MASK1, 8'h03);
    expQ.push_back({16'h0, 4'h7, 4'he, addr});
    serve(4'h8, 1'b1);
    rd(`DMAC_OFF_CMD, 8'h08);
    wr(`DMAC_OFF_CLRBP, 8'h00);
    rd(4'h7, 8'h04);
    rd(4'h7, 8'h00);
    $display("test external end done");
    // Software request on channel 0 with active-high grants, then a master clear.
    wr(`DMAC_OFF_CMD, 8'h80);
    wr(`DMAC_OFF_MASKALL, 8'h0e);
    expQ.push_back({16'h0, 4'h1, 4'he, 16'h0000});
    wr(`DMAC_OFF_REQ, 8'h04);
    serve(4'h0, 1'b0);
    rd(`DMAC_OFF_CMD, 8'h01);
    wr(`DMAC_OFF_CLEAR, 8'h00);
    check({36'h0, channelGrant}, 40'hf);
    rd(`DMAC_OFF_CMD, 8'h00);
    $display("test software request done");
    poke(4'h2);
    check(40'(expQ.size()), 40'h0);
    $display("test masks done");
    giveVerdict();
  end
endmodule : dmac_bus_interface_test
